/* File: common/bts_pkg.sv */
// bts_pkg: constants and types shared by the bus trigger sequencer
package bts_pkg;
  // target bus widths
  localparam int unsigned BTS_ADDR_W   = 24;
  localparam int unsigned BTS_DATA_W   = 16;
  localparam int unsigned BTS_CTRL_W   = 8;
  localparam int unsigned BTS_EXT_W    = 6;
  localparam int unsigned BTS_IPL_W    = 3;
  // qualifier lines: address, data, control, ipl, external = 57 here; 79 at most
  localparam int unsigned BTS_QUAL_MAX = 79;
  localparam int unsigned BTS_QUAL_W   = BTS_ADDR_W + BTS_DATA_W + BTS_CTRL_W
                                         + BTS_IPL_W + BTS_EXT_W;
  localparam int unsigned BTS_TERMS    = 7;
  localparam int unsigned BTS_TERM_IW  = 3;
  localparam int unsigned BTS_CNT_W    = 16;
  localparam int unsigned BTS_TIME_W   = 32;
  localparam int unsigned BTS_HIST_W   = 24;
  localparam int unsigned BTS_DISC_SEL = 4;
  localparam int unsigned BTS_DISC_BINS = 16;
  // control bit positions within ctrl_i
  localparam int unsigned BTS_CTRL_WRITE_BIT  = 0;
  localparam int unsigned BTS_CTRL_VECT_BIT   = 1;
  localparam int unsigned BTS_CTRL_IACK_BIT   = 2;
  // reset values
  localparam logic [BTS_CNT_W-1:0]  BTS_CNT_RST  = 16'h0000;
  localparam logic [BTS_TIME_W-1:0] BTS_TIME_RST = 32'h0000_0000;
  localparam logic [BTS_HIST_W-1:0] BTS_HIST_RST = 24'h00_0000;
  localparam logic [BTS_TERM_IW-1:0] BTS_TERM_RST = 3'h0;
  // one qualifier word: value and care mask
  typedef logic [BTS_QUAL_W-1:0] bts_qual_t;

  typedef enum logic [1:0] {
    BTS_ST_IDLE  = 2'b00,
    BTS_ST_SEEK  = 2'b01,
    BTS_ST_DONE  = 2'b10
  } bts_seq_e;

  // compare a sampled qualifier word against value under care mask
  function automatic logic bts_qual_hit(input bts_qual_t s, input bts_qual_t v,
                                        input bts_qual_t m);
    return ((s ^ v) & m) == '0;
  endfunction

  // inclusive address window test
  function automatic logic bts_in_win(input logic [BTS_ADDR_W-1:0] a,
                                      input logic [BTS_ADDR_W-1:0] lo,
                                      input logic [BTS_ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

/* File: rtl/bts_bus_sampler.sv */
// bts_bus_sampler: synchronises target bus pins and samples once per qualified cycle
`timescale 1ns/1ns
module bts_bus_sampler
  import bts_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_b_i,
  // target pins
  input  wire logic                  bus_clk_qual_i,
  input  wire logic                  emu_mem_access_i,
  input  wire logic [BTS_QUAL_W-1:0] pins_i,
  // configuration
  input  wire logic                  slope_rise_i,
  // sampled bus state
  output logic                       smp_vld_o,
  output logic [BTS_QUAL_W-1:0]      smp_o
);
  typedef struct packed {
    logic                  clk_s1;
    logic                  clk_s2;
    logic                  clk_s3;
    logic                  emu_s1;
    logic                  emu_s2;
    logic [BTS_QUAL_W-1:0] pin_s1;
    logic [BTS_QUAL_W-1:0] pin_s2;
    logic                  vld;
    logic [BTS_QUAL_W-1:0] smp;
  } bts_smp_s;

  bts_smp_s st_q;
  bts_smp_s st_d;
  logic     edge_hit;

  always_comb begin
    st_d        = st_q;
    st_d.clk_s1 = bus_clk_qual_i;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    st_d.emu_s1 = emu_mem_access_i;
    st_d.emu_s2 = st_q.emu_s1;
    st_d.pin_s1 = pins_i;
    st_d.pin_s2 = st_q.pin_s1;
    edge_hit    = slope_rise_i ? (st_q.clk_s2 & ~st_q.clk_s3)
                               : (~st_q.clk_s2 & st_q.clk_s3);
    // one sample per selected edge; emulation-memory cycles dropped
    st_d.vld    = edge_hit & ~st_q.emu_s2;
    if (edge_hit) begin
      st_d.smp = st_q.pin_s2;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign smp_vld_o = st_q.vld;
  assign smp_o     = st_q.smp;
endmodule

/* File: rtl/bts_histogram.sv */
// bts_histogram: address range and discrete signal histogram counters
`timescale 1ns/1ns
module bts_histogram
  import bts_pkg::*;
#(
  parameter int unsigned RANGES = 4
)(
  // clock and reset
  input  wire logic                              core_clk_i,
  input  wire logic                              rst_b_i,
  // sampled bus
  input  wire logic                              smp_vld_i,
  input  wire logic [BTS_ADDR_W-1:0]             addr_i,
  input  wire logic [BTS_DISC_SEL-1:0]           disc_i,
  // control
  input  wire logic                              run_i,
  input  wire logic                              clear_i,
  input  wire logic [RANGES*BTS_ADDR_W-1:0]      lo_i,
  input  wire logic [RANGES*BTS_ADDR_W-1:0]      hi_i,
  // counts
  output logic [RANGES*BTS_HIST_W-1:0]           addr_cnt_o,
  output logic [BTS_DISC_BINS*BTS_HIST_W-1:0]    disc_cnt_o
);
  initial begin
    if (RANGES < 1 || RANGES > 16) begin
      $error("bts_histogram: RANGES out of range");
    end
  end

  typedef struct packed {
    logic [RANGES-1:0][BTS_HIST_W-1:0]        acnt;
    logic [BTS_DISC_BINS-1:0][BTS_HIST_W-1:0] dcnt;
  } bts_hist_s;

  bts_hist_s st_q;
  bts_hist_s st_d;

  // saturating increment
  function automatic logic [BTS_HIST_W-1:0] bts_sat_inc(input logic [BTS_HIST_W-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction

  always_comb begin
    st_d = st_q;
    if (clear_i) begin
      st_d = '0;
    end else if (run_i && smp_vld_i) begin
      for (int i = 0; i < RANGES; i++) begin
        if (bts_in_win(addr_i, lo_i[i*BTS_ADDR_W +: BTS_ADDR_W],
                       hi_i[i*BTS_ADDR_W +: BTS_ADDR_W])) begin
          st_d.acnt[i] = bts_sat_inc(st_q.acnt[i]);
        end
      end
      st_d.dcnt[disc_i] = bts_sat_inc(st_q.dcnt[disc_i]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign addr_cnt_o = st_q.acnt;
  assign disc_cnt_o = st_q.dcnt;
endmodule

/* File: rtl/bts_trigger_top.sv */
// bts_trigger_top: sequential, window and event-breakpoint trigger logic
`timescale 1ns/1ns
// Overview of operation
// - program breakpoint halts before instruction executes
// - up to seven events over qualifier lines
// - event breakpoint halts after qualifying event
// - terms match only in configured order
// - sequence end starts or stops trace
// - reset term restarts search at term one
// - measure time from start to end term
// - window stores inside or outside by polarity
// - both window limits programmable
// - address histogram counts accesses per range
// - discrete histogram counts four-signal combinations
// - term satisfied after programmed occurrence count
// - match interrupt level, vector fetch, write address
// - emulation memory accesses stay invisible
module bts_trigger_top
  import bts_pkg::*;
#(
  parameter int unsigned HIST_RANGES = 4
)(
  // clock and reset
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_b_i,
  // target socket pins
  input  wire logic                                bus_clk_qual_i,
  input  wire logic                                emu_mem_access_i,
  input  wire logic [BTS_ADDR_W-1:0]               addr_i,
  input  wire logic [BTS_DATA_W-1:0]               data_i,
  input  wire logic [BTS_CTRL_W-1:0]               ctrl_i,
  input  wire logic [BTS_IPL_W-1:0]                ipl_i,
  input  wire logic [BTS_EXT_W-1:0]                ext_i,
  input  wire logic                                fetch_i,
  // general control
  input  wire logic                                slope_rise_i,
  input  wire logic                                arm_i,
  input  wire logic                                win_mode_i,
  input  wire logic                                trig_stops_trace_i,
  input  wire logic                                brk_en_i,
  // program breakpoint
  input  wire logic                                pbrk_en_i,
  input  wire logic [BTS_ADDR_W-1:0]               pbrk_lo_i,
  input  wire logic [BTS_ADDR_W-1:0]               pbrk_hi_i,
  // sequence terms
  input  wire logic [BTS_TERM_IW-1:0]              num_terms_i,
  input  wire logic [BTS_TERMS*BTS_QUAL_W-1:0]     term_val_i,
  input  wire logic [BTS_TERMS*BTS_QUAL_W-1:0]     term_mask_i,
  input  wire logic [BTS_TERMS*BTS_CNT_W-1:0]      term_cnt_i,
  input  wire logic                                rst_term_en_i,
  input  wire logic [BTS_QUAL_W-1:0]               rst_term_val_i,
  input  wire logic [BTS_QUAL_W-1:0]               rst_term_mask_i,
  // timing
  input  wire logic [BTS_TERM_IW-1:0]              time_start_i,
  input  wire logic [BTS_TERM_IW-1:0]              time_end_i,
  // window
  input  wire logic [BTS_ADDR_W-1:0]               win_lo_i,
  input  wire logic [BTS_ADDR_W-1:0]               win_hi_i,
  input  wire logic                                win_inside_i,
  // histogram
  input  wire logic                                hist_run_i,
  input  wire logic                                hist_clear_i,
  input  wire logic [HIST_RANGES*BTS_ADDR_W-1:0]   hist_lo_i,
  input  wire logic [HIST_RANGES*BTS_ADDR_W-1:0]   hist_hi_i,
  input  wire logic [2*BTS_DISC_SEL-1:0]           disc_sel_i,
  // target control
  output logic                                     halt_req_o,
  // trace control and status
  output logic                                     trace_en_o,
  output logic                                     store_o,
  output logic [BTS_QUAL_W-1:0]                    store_data_o,
  output logic                                     triggered_o,
  output logic [BTS_TERM_IW-1:0]                   seq_pos_o,
  output logic [BTS_TIME_W-1:0]                    elapsed_o,
  output logic                                     elapsed_vld_o,
  // histogram counts
  output logic [HIST_RANGES*BTS_HIST_W-1:0]        addr_hist_o,
  output logic [BTS_DISC_BINS*BTS_HIST_W-1:0]      disc_hist_o
);
  initial begin
    if (BTS_QUAL_W > BTS_QUAL_MAX) begin
      $error("bts_trigger_top: qualifier width above limit");
    end
    if (HIST_RANGES < 1 || HIST_RANGES > 16) begin
      $error("bts_trigger_top: HIST_RANGES out of range");
    end
  end

  typedef struct packed {
    bts_seq_e                              seq;
    logic [BTS_TERM_IW-1:0]                pos;
    logic [BTS_CNT_W-1:0]                  occ;
    logic                                  trace_en;
    logic                                  triggered;
    logic                                  halt;
    logic                                  store;
    logic [BTS_QUAL_W-1:0]                 store_data;
    logic                                  timing;
    logic [BTS_TIME_W-1:0]                 tcnt;
    logic [BTS_TIME_W-1:0]                 elapsed;
    logic                                  elapsed_vld;
    logic                                  arm_prev;
  } bts_top_s;

  bts_top_s st_q;
  bts_top_s st_d;

  logic                    smp_vld;
  logic [BTS_QUAL_W-1:0]   smp;
  logic [BTS_ADDR_W-1:0]   s_addr;
  logic [BTS_CTRL_W-1:0]   s_ctrl;
  logic [BTS_EXT_W-1:0]    s_ext;
  logic [BTS_DISC_SEL-1:0] disc_bits;
  logic                    s_fetch;
  logic                    fetch_s1;
  logic                    fetch_s2;

  // qualifier word layout: {ext, ipl, ctrl, data, addr}
  assign s_addr = smp[BTS_ADDR_W-1:0];
  assign s_ctrl = smp[BTS_ADDR_W+BTS_DATA_W +: BTS_CTRL_W];
  assign s_ext  = smp[BTS_QUAL_W-1 -: BTS_EXT_W];

  // all qualifier lines go through the sampler, so ipl, vector fetch and
  // write strobe are just masked bits of one term word
  bts_bus_sampler u_sampler (
    .core_clk_i       (core_clk_i),
    .rst_b_i          (rst_b_i),
    .bus_clk_qual_i   (bus_clk_qual_i),
    .emu_mem_access_i (emu_mem_access_i),
    .pins_i           ({ext_i, ipl_i, ctrl_i, data_i, addr_i}),
    .slope_rise_i     (slope_rise_i),
    .smp_vld_o        (smp_vld),
    .smp_o            (smp)
  );

  always_comb begin
    for (int k = 0; k < BTS_DISC_SEL; k++) begin
      disc_bits[k] = s_ext[disc_sel_i[k*2 +: 2]];
    end
  end

  bts_histogram #(
    .RANGES (HIST_RANGES)
  ) u_hist (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .smp_vld_i  (smp_vld),
    .addr_i     (s_addr),
    .disc_i     (disc_bits),
    .run_i      (hist_run_i),
    .clear_i    (hist_clear_i),
    .lo_i       (hist_lo_i),
    .hi_i       (hist_hi_i),
    .addr_cnt_o (addr_hist_o),
    .disc_cnt_o (disc_hist_o)
  );

  logic term_hit;
  logic rst_hit;
  logic last_term;
  logic in_win;
  logic [BTS_CNT_W-1:0] need;

  always_comb begin
    st_d           = st_q;
    st_d.store     = 1'b0;
    st_d.arm_prev  = arm_i;
    term_hit       = bts_qual_hit(smp, term_val_i[st_q.pos*BTS_QUAL_W +: BTS_QUAL_W],
                                  term_mask_i[st_q.pos*BTS_QUAL_W +: BTS_QUAL_W]);
    rst_hit        = rst_term_en_i && bts_qual_hit(smp, rst_term_val_i, rst_term_mask_i);
    last_term      = (st_q.pos == num_terms_i);
    need           = term_cnt_i[st_q.pos*BTS_CNT_W +: BTS_CNT_W];
    in_win         = bts_in_win(s_addr, win_lo_i, win_hi_i);
    if (st_q.timing) begin
      st_d.tcnt = st_q.tcnt + 1'b1;
    end
    // program breakpoint: asserted on the fetch cycle itself, before execution
    if (pbrk_en_i && smp_vld && s_fetch &&
        bts_in_win(s_addr, pbrk_lo_i, pbrk_hi_i)) begin
      st_d.halt = 1'b1;
    end
    if (arm_i && !st_q.arm_prev) begin
      st_d.seq         = BTS_ST_SEEK;
      st_d.pos         = BTS_TERM_RST;
      st_d.occ         = BTS_CNT_RST;
      st_d.triggered   = 1'b0;
      st_d.halt        = 1'b0;
      st_d.timing      = 1'b0;
      st_d.elapsed_vld = 1'b0;
      st_d.trace_en    = trig_stops_trace_i;
    end else if (!arm_i) begin
      st_d.seq       = BTS_ST_IDLE;
      st_d.halt      = 1'b0;
      st_d.triggered = 1'b0;
    end else if (smp_vld) begin
      if (win_mode_i) begin
        if (in_win == win_inside_i) begin
          st_d.store      = 1'b1;
          st_d.store_data = smp;
        end
      end else begin
        st_d.store      = st_q.trace_en;
        st_d.store_data = smp;
      end
      case (st_q.seq)
        BTS_ST_SEEK: begin
          if (rst_hit) begin
            st_d.pos    = BTS_TERM_RST;
            st_d.occ    = BTS_CNT_RST;
            st_d.timing = 1'b0;
          end else if (term_hit) begin
            // only the current term can advance; others are ignored
            if (st_q.occ + 1'b1 >= need) begin
              st_d.occ = BTS_CNT_RST;
              if (st_q.pos == time_start_i) begin
                st_d.timing = 1'b1;
                st_d.tcnt   = BTS_TIME_RST;
              end
              if (st_q.timing && st_q.pos == time_end_i) begin
                st_d.timing      = 1'b0;
                st_d.elapsed     = st_q.tcnt + 1'b1;
                st_d.elapsed_vld = 1'b1;
              end
              if (last_term) begin
                st_d.seq       = BTS_ST_DONE;
                st_d.triggered = 1'b1;
                st_d.trace_en  = !trig_stops_trace_i;
                st_d.halt      = st_q.halt | brk_en_i;
              end else begin
                st_d.pos = st_q.pos + 1'b1;
              end
            end else begin
              st_d.occ = st_q.occ + 1'b1;
            end
          end
        end
        BTS_ST_DONE: begin
          st_d.seq = BTS_ST_DONE;
        end
        default: begin
          st_d.seq = BTS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_q     <= '0;
      fetch_s1 <= 1'b0;
      fetch_s2 <= 1'b0;
    end else begin
      st_q     <= st_d;
      fetch_s1 <= fetch_i;
      fetch_s2 <= fetch_s1;
    end
  end

  assign s_fetch       = fetch_s2 & ~s_ctrl[BTS_CTRL_WRITE_BIT];
  assign halt_req_o    = st_q.halt;
  assign trace_en_o    = st_q.trace_en;
  assign store_o       = st_q.store;
  assign store_data_o  = st_q.store_data;
  assign triggered_o   = st_q.triggered;
  assign seq_pos_o     = st_q.pos;
  assign elapsed_o     = st_q.elapsed;
  assign elapsed_vld_o = st_q.elapsed_vld;
endmodule

/* File: tb/bts_trigger_props.sv */
// checker for the trigger sequencer top-level ports
`timescale 1ns/1ns
module bts_trigger_props
  import bts_pkg::*;
#(
  parameter int unsigned HIST_RANGES = 4
)(
  // clock and reset
  input wire logic                                core_clk_i,
  input wire logic                                rst_b_i,
  // control inputs
  input wire logic                                emu_mem_access_i,
  input wire logic                                arm_i,
  input wire logic                                win_mode_i,
  input wire logic                                trig_stops_trace_i,
  input wire logic                                brk_en_i,
  input wire logic                                pbrk_en_i,
  input wire logic [BTS_ADDR_W-1:0]               win_lo_i,
  input wire logic [BTS_ADDR_W-1:0]               win_hi_i,
  input wire logic                                win_inside_i,
  input wire logic                                hist_clear_i,
  // outputs watched
  input wire logic                                halt_req_o,
  input wire logic                                trace_en_o,
  input wire logic                                store_o,
  input wire logic [BTS_QUAL_W-1:0]               store_data_o,
  input wire logic                                triggered_o,
  input wire logic [BTS_TIME_W-1:0]               elapsed_o,
  input wire logic                                elapsed_vld_o,
  input wire logic [HIST_RANGES*BTS_HIST_W-1:0]   addr_hist_o,
  input wire logic [BTS_DISC_BINS*BTS_HIST_W-1:0] disc_hist_o
);
  logic [BTS_ADDR_W-1:0] st_a;
  assign st_a = store_data_o[BTS_ADDR_W-1:0];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_store_pulse: assert property (store_o |=> !store_o)
    else $error("store strobe too long");
  a_win_store: assert property (store_o && win_mode_i |-> ((st_a >= win_lo_i && st_a <= win_hi_i) == win_inside_i))
    else $error("store on wrong window side");
  a_emu_hidden: assert property (emu_mem_access_i [*8] |-> !store_o)
    else $error("store from emulation cycle");
  a_halt_unarm: assert property (!arm_i [*2] |-> !halt_req_o && !triggered_o)
    else $error("halt or trigger while disarmed");
  a_halt_hold: assert property (halt_req_o && arm_i && $past(arm_i) |=> halt_req_o)
    else $error("halt dropped while armed");
  a_trig_hold: assert property (triggered_o && arm_i && $past(arm_i) |=> triggered_o)
    else $error("trigger dropped while armed");
  a_trace_flip: assert property ($rose(triggered_o) |-> trace_en_o != trig_stops_trace_i)
    else $error("trace enable wrong at trigger");
  a_halt_cause: assert property ($rose(halt_req_o) |-> $past(brk_en_i) || $past(pbrk_en_i))
    else $error("halt without breakpoint");
  a_time_hold: assert property (elapsed_vld_o && arm_i && $past(arm_i) |=> elapsed_vld_o && $stable(elapsed_o))
    else $error("elapsed time changed");
  a_hist_clear: assert property (hist_clear_i |=> addr_hist_o == '0 && disc_hist_o == '0)
    else $error("histogram not cleared");
endmodule

/* File: tb/bts_target_bus.sv */
// target processor bus model: one qualified bus cycle per call
`timescale 1ns/1ns
module bts_target_bus
  import bts_pkg::*;
(
  // clock
  input  wire logic                 core_clk_i,
  // socket pins
  output logic                      bus_clk_qual_o,
  output logic                      emu_mem_access_o,
  output logic [BTS_ADDR_W-1:0]     addr_o,
  output logic [BTS_DATA_W-1:0]     data_o,
  output logic [BTS_CTRL_W-1:0]     ctrl_o,
  output logic [BTS_IPL_W-1:0]      ipl_o,
  output logic [BTS_EXT_W-1:0]      ext_o,
  output logic                      fetch_o
);
  initial begin
    {bus_clk_qual_o, emu_mem_access_o, fetch_o} = 3'h0;
    {addr_o, data_o, ctrl_o, ipl_o, ext_o} = '0;
  end
  task automatic cycle(input logic [23:0] a, input logic [15:0] d, input logic [7:0] c,
                       input logic [2:0] i, input logic [5:0] e, input logic f,
                       input logic emu);
    @(posedge core_clk_i);
    {addr_o, data_o, ctrl_o, ipl_o, ext_o, fetch_o} <= {a, d, c, i, e, f};
    emu_mem_access_o <= emu;
    repeat (4) @(posedge core_clk_i);
    bus_clk_qual_o <= 1'b1;
    repeat (7) @(posedge core_clk_i);
    bus_clk_qual_o <= 1'b0;
    emu_mem_access_o <= 1'b0;
    // released lines show the inverse, not the last value
    {addr_o, data_o, ctrl_o, ipl_o, ext_o, fetch_o} <= ~{a, d, c, i, e, f};
  endtask
endmodule

/* File: tb/tb_bus_trigger_sequencer.sv */
// self-checking bench for the trigger sequencer
`timescale 1ns/1ns
module tb_bus_trigger_sequencer;
  import bts_pkg::*;
  localparam int unsigned HR  = 4;
  typedef struct packed {logic [23:0] a, lo, hi; logic ins, emu, exp;} bts_row_s;
  localparam bts_qual_t AM = {33'h0, 24'hffffff};
  localparam bts_qual_t WM = {17'h00001, 16'hffff, 24'hffffff};
  logic core_clk_i = 1'b0, rst_b_i = 1'b0, slope_rise_i = 1'b1, arm_i = 1'b0;
  logic win_mode_i = 1'b0, trig_stops_trace_i = 1'b0, brk_en_i = 1'b0, pbrk_en_i = 1'b0;
  logic rst_term_en_i = 1'b0, win_inside_i = 1'b0, hist_run_i = 1'b0, hist_clear_i = 1'b0;
  logic [BTS_ADDR_W-1:0] pbrk_lo_i = '0, pbrk_hi_i = '0, win_lo_i = '0, win_hi_i = '0;
  logic [BTS_TERM_IW-1:0] num_terms_i = '0, time_start_i = '0, time_end_i = '0;
  logic [BTS_TERMS*BTS_QUAL_W-1:0] term_val_i = '0, term_mask_i = '0;
  logic [BTS_TERMS*BTS_CNT_W-1:0] term_cnt_i = '0;
  bts_qual_t rst_term_val_i = '0, rst_term_mask_i = '0;
  logic [HR*BTS_ADDR_W-1:0] hist_lo_i = '0, hist_hi_i = '0;
  logic [2*BTS_DISC_SEL-1:0] disc_sel_i = '0;
  logic bus_clk_qual_i, emu_mem_access_i, fetch_i, halt_req_o, trace_en_o, store_o;
  logic triggered_o, elapsed_vld_o;
  logic [BTS_ADDR_W-1:0] addr_i, st_addr;
  logic [BTS_DATA_W-1:0] data_i;
  logic [BTS_CTRL_W-1:0] ctrl_i;
  logic [BTS_IPL_W-1:0] ipl_i;
  logic [BTS_EXT_W-1:0] ext_i;
  logic [BTS_QUAL_W-1:0] store_data_o;
  logic [BTS_TERM_IW-1:0] seq_pos_o;
  logic [BTS_TIME_W-1:0] elapsed_o;
  logic [HR*BTS_HIST_W-1:0] addr_hist_o;
  logic [BTS_DISC_BINS*BTS_HIST_W-1:0] disc_hist_o;
  int err_count = 0, checked = 0, stores = 0;
  bts_row_s rows [9] = '{
    {24'h0010ff, 24'h001000, 24'h0010ff, 3'b101}, {24'h001000, 24'h001000, 24'h0010ff, 3'b101},
    {24'h000fff, 24'h001000, 24'h0010ff, 3'b100}, {24'h001100, 24'h001000, 24'h0010ff, 3'b001},
    {24'h001000, 24'h001000, 24'h0010ff, 3'b000}, {24'h005555, 24'h005555, 24'h005555, 3'b101},
    {24'hffffff, 24'h000000, 24'hffffff, 3'b101}, {24'h000000, 24'h000000, 24'hffffff, 3'b000},
    {24'h001000, 24'h001000, 24'h0010ff, 3'b110}};

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) begin
    if (store_o === 1'b1) begin
      stores++;
      st_addr = store_data_o[BTS_ADDR_W-1:0];
    end
  end

  bts_trigger_top #(.HIST_RANGES(HR)) dut (.core_clk_i, .rst_b_i, .bus_clk_qual_i,
    .emu_mem_access_i, .addr_i, .data_i, .ctrl_i, .ipl_i, .ext_i, .fetch_i, .slope_rise_i,
    .arm_i, .win_mode_i, .trig_stops_trace_i, .brk_en_i, .pbrk_en_i, .pbrk_lo_i, .pbrk_hi_i,
    .num_terms_i, .term_val_i, .term_mask_i, .term_cnt_i, .rst_term_en_i, .rst_term_val_i,
    .rst_term_mask_i, .time_start_i, .time_end_i, .win_lo_i, .win_hi_i, .win_inside_i,
    .hist_run_i, .hist_clear_i, .hist_lo_i, .hist_hi_i, .disc_sel_i, .halt_req_o,
    .trace_en_o, .store_o, .store_data_o, .triggered_o, .seq_pos_o, .elapsed_o,
    .elapsed_vld_o, .addr_hist_o, .disc_hist_o);
  bts_target_bus bus (.core_clk_i, .bus_clk_qual_o(bus_clk_qual_i),
    .emu_mem_access_o(emu_mem_access_i), .addr_o(addr_i), .data_o(data_i), .ctrl_o(ctrl_i),
    .ipl_o(ipl_i), .ext_o(ext_i), .fetch_o(fetch_i));

  function automatic bts_qual_t qw(input logic [23:0] a, input logic [15:0] d,
                                   input logic [7:0] c, input logic [2:0] i);
    return {6'h00, i, c, d, a};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic term(input int i, input bts_qual_t v, input bts_qual_t m, input int c);
    term_val_i[i*BTS_QUAL_W +: BTS_QUAL_W] <= v;
    term_mask_i[i*BTS_QUAL_W +: BTS_QUAL_W] <= m;
    term_cnt_i[i*BTS_CNT_W +: BTS_CNT_W] <= 16'(c);
  endtask
  task automatic arm();
    arm_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    arm_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [23:0] a, input logic [2:0] i, input logic [5:0] e,
                    input logic f);
    bus.cycle(a, 16'h0000, 8'h00, i, e, f, 1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    int n;
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    chk("outputs", 0, {halt_req_o, trace_en_o, triggered_o, elapsed_vld_o, seq_pos_o});
    chk("hist", 0, 32'(|{addr_hist_o, disc_hist_o}));
    $display("test reset done");
    term(0, qw(24'hfffff0, 0, 0, 0), AM, 0);
    win_mode_i <= 1'b1;
    arm();
    for (int i = 0; i < 9; i++) begin
      {win_lo_i, win_hi_i, win_inside_i} <= {rows[i].lo, rows[i].hi, rows[i].ins};
      n = stores;
      bus.cycle(rows[i].a, 16'h0000, 8'h00, 3'h0, 6'h00, 1'b0, rows[i].emu);
      chk("store count", 32'(rows[i].exp), stores - n);
      if (rows[i].exp) chk("store addr", rows[i].a, st_addr);
    end
    $display("test window done");
    {win_mode_i, brk_en_i, num_terms_i, rst_term_en_i} <= {2'b01, 3'h2, 1'b1};
    term(0, qw(24'h000100, 0, 0, 0), AM, 0);
    term(1, qw(24'h000200, 0, 0, 0), AM, 10);
    term(2, qw(24'h001030, 16'h0077, 8'h01, 0), WM, 0);
    {rst_term_val_i, rst_term_mask_i} <= {qw(24'h000300, 0, 0, 0), AM};
    {time_start_i, time_end_i} <= {3'h0, 3'h2};
    arm();
    chk("trace", 0, trace_en_o);
    rd(24'h000200, 0, 0, 0);
    chk("position", 0, seq_pos_o);
    rd(24'h000100, 0, 0, 0);
    chk("position", 1, seq_pos_o);
    repeat (9) rd(24'h000200, 0, 0, 0);
    chk("position", 1, seq_pos_o);
    rd(24'h000300, 0, 0, 0);
    chk("position", 0, seq_pos_o);
    rd(24'h000100, 0, 0, 0);
    repeat (10) rd(24'h000200, 0, 0, 0);
    chk("position", 2, seq_pos_o);
    bus.cycle(24'h001030, 16'h0077, 8'h01, 3'h0, 6'h00, 1'b0, 1'b0);
    chk("triggered", 1, triggered_o);
    chk("trace", 1, trace_en_o);
    chk("halt", 1, halt_req_o);
    chk("elapsed valid", 1, elapsed_vld_o);
    chk("elapsed", 132, elapsed_o);
    $display("test sequence done");
    {brk_en_i, num_terms_i, rst_term_en_i} <= {1'b0, 3'h0, 1'b0};
    term(0, qw(0, 0, 0, 3'h4), qw(0, 0, 0, 3'h7), 0);
    arm();
    rd(24'h000000, 3'h3, 0, 0);
    chk("triggered", 0, triggered_o);
    rd(24'h000000, 3'h4, 0, 0);
    chk("triggered", 1, triggered_o);
    term(0, qw(24'h000070, 0, 8'h02, 0), qw(24'hffffff, 0, 8'h02, 0), 0);
    arm();
    rd(24'h000070, 0, 0, 0);
    chk("triggered", 0, triggered_o);
    bus.cycle(24'h000070, 16'h0000, 8'h02, 3'h0, 6'h00, 1'b0, 1'b0);
    chk("triggered", 1, triggered_o);
    $display("test qualifier done");
    term(0, qw(24'hfffff0, 0, 0, 0), AM, 0);
    {pbrk_en_i, pbrk_lo_i, pbrk_hi_i} <= {1'b1, 24'h000400, 24'h000403};
    arm();
    rd(24'h000404, 0, 0, 1);
    chk("halt", 0, halt_req_o);
    rd(24'h000402, 0, 0, 0);
    chk("halt", 0, halt_req_o);
    rd(24'h000402, 0, 0, 1);
    chk("halt", 1, halt_req_o);
    $display("test program break done");
    pbrk_en_i <= 1'b0;
    hist_lo_i <= {{3{24'hfff000}}, 24'h000000};
    hist_hi_i <= {{3{24'hffffff}}, 24'h0000ff};
    {disc_sel_i, hist_clear_i} <= {8'he4, 1'b1};
    @(posedge core_clk_i);
    {hist_clear_i, hist_run_i} <= 2'b01;
    repeat (3) rd(24'h000010, 0, 6'h05, 0);
    rd(24'h000800, 0, 6'h05, 0);
    chk("address hist", 3, addr_hist_o[BTS_HIST_W-1:0]);
    chk("discrete hist", 4, disc_hist_o[5*BTS_HIST_W +: BTS_HIST_W]);
    hist_clear_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk("hist cleared", 0, 32'(|{addr_hist_o, disc_hist_o}));
    $display("test histogram done");
    complete_run();
  end
endmodule

bind bts_trigger_top bts_trigger_props #(.HIST_RANGES(HIST_RANGES)) u_props (.core_clk_i,
  .rst_b_i, .emu_mem_access_i, .arm_i, .win_mode_i, .trig_stops_trace_i, .brk_en_i,
  .pbrk_en_i, .win_lo_i, .win_hi_i, .win_inside_i, .hist_clear_i, .halt_req_o, .trace_en_o,
  .store_o, .store_data_o, .triggered_o, .elapsed_o, .elapsed_vld_o, .addr_hist_o,
  .disc_hist_o);
